// ---- src/psr_pkg.sv ----
// Purpose: shared constants and types for the synthesizer scan chain reconfiguration link
// Assumes: system clock of 4 ns; chain layout is one 18-bit field per post-scale counter, then a tail
// Notes:   chain bit 0 is the first bit shifted in
package psr_pkg;
  // per-counter field inside the chain
  localparam int CNT_BITS  = 8;        // high and low count width
  localparam int FLD_LEN   = 18;       // bits per counter field
  localparam int FLD_LOW   = 0;        // low count lsb
  localparam int FLD_HIGH  = 8;        // high count lsb
  localparam int FLD_BYP   = 16;       // bypass bit
  localparam int FLD_ODD   = 17;       // odd half-cycle correction bit
  // tail after the post-scale counters, offsets from its base
  localparam int TAIL_M    = 0;        // feedback counter field
  localparam int TAIL_N    = 18;       // pre-scale counter field
  localparam int TAIL_CP   = 36;       // pump current, 3 bits
  localparam int TAIL_K    = 39;       // post oscillator divider, 1 bit
  localparam int TAIL_LFC  = 40;       // filter capacitor, 2 bits
  localparam int TAIL_LFR  = 42;       // filter resistor, 5 bits
  localparam int TAIL_LEN  = 54;       // tail length incl. 7 unused bits
  localparam int NUM_C_WIDE   = 10;    // ten-output variant
  localparam int NUM_C_NARROW = 7;     // seven-output variant
  // synchroniser input positions in the device
  localparam int SY_CLK = 0;
  localparam int SY_EN  = 1;
  localparam int SY_DIN = 2;
  localparam int SY_UPD = 3;
  localparam int SY_RST = 4;
  // timing
  localparam int SYS_PERIOD_PS      = 4000;
  localparam int SCAN_MAX_MHZ       = 100;
  localparam int SCAN_MIN_PERIOD_PS = 1000000 / SCAN_MAX_MHZ;
  localparam int SCAN_HALF_CYC      = (SCAN_MIN_PERIOD_PS + 2 * SYS_PERIOD_PS - 1) / (2 * SYS_PERIOD_PS);
  localparam int ARST_MIN_PS        = 10000;
  localparam int ARST_CYC           = (ARST_MIN_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
  // controller register map
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_IMAGE  = 8'h20;
  localparam int IMG_WORDS    = 8;     // image words, 256 bits
  localparam int CTRL_GO      = 0;     // write 1 to start
  localparam int CTRL_AUTORST = 1;     // pulse synth reset after update
  localparam int STAT_BUSY    = 0;     // sequence running
  localparam int STAT_PHASE   = 1;     // phase must be restored, write 1 clears
  localparam int STAT_RECONF  = 2;     // device busy line
  localparam logic CTRL_AUTORST_RST = 1'b1;
  localparam logic [FLD_LEN-1:0] CNT_CFG_RST = 18'h10000; // counter bypassed
  // chain length of a variant
  function automatic int chain_len(input int n);
    return n * FLD_LEN + TAIL_LEN;
  endfunction
  // controller sequence, gray along the path through ST_ARST; ST_WLO straight to ST_IDLE flips two bits
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_ENA   = 3'h1,
    ST_SHIFT = 3'h3,
    ST_STOP  = 3'h2,
    ST_UPD   = 3'h6,
    ST_WHI   = 3'h7,
    ST_WLO   = 3'h5,
    ST_ARST  = 3'h4
  } psr_state_type;
endpackage

// ---- src/psr_link_if.sv ----
// Purpose: serial reconfiguration link between controller and synthesizer
// Assumes: all signals are plain levels; receivers synchronise them
// Notes:   no clocking block
interface psr_link_if;
  logic scan_clk;     // shift clock from controller
  logic scan_en;      // shift enable, active high
  logic scan_din;     // serial data into chain
  logic cfg_apply;    // apply chain to live settings
  logic synth_rst;    // synthesizer reset, active high
  logic reconf_busy;  // update in progress
  logic scan_dout;    // chain contents out
  modport dev (input scan_clk, scan_en, scan_din, cfg_apply, synth_rst, output reconf_busy, scan_dout);
  modport ctl (output scan_clk, scan_en, scan_din, cfg_apply, synth_rst, input reconf_busy, scan_dout);
endinterface

// ---- src/psr_post_div.sv ----
// Purpose: one post-scale output divider with high/low counts, bypass and odd correction
// Assumes: oscillator runs at half the system clock; vco_i is its level this cycle
// Notes:   a new setting waits for the start of the next output period
module psr_post_div
  import psr_pkg::*;
(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               ce_i,
  input  wire logic               vco_i,
  input  wire logic               restart_i,
  input  wire logic               load_i,
  input  wire logic [FLD_LEN-1:0] cfg_i,
  output logic                    busy_o,
  output logic                    div_o
);
  typedef struct packed {
    logic [FLD_LEN-1:0] live;  // setting in use
    logic [FLD_LEN-1:0] pend;  // setting waiting for boundary
    logic               busy;  // pend not yet taken
    logic [9:0]         cnt;   // half cycles left in phase
    logic               out;   // divided clock
  } psr_div_type;

  psr_div_type s, next_s;
  logic [FLD_LEN-1:0] use_cfg;  // setting for this cycle
  logic               bound;    // period boundary on an oscillator rise

  // count in half oscillator cycles, zero stands for 256
  function automatic logic [9:0] half_cyc(input logic [CNT_BITS-1:0] v);
    return (v == 8'h00) ? 10'h200 : {1'b0, v, 1'b0};
  endfunction

  // next state
  always_comb begin
    next_s = s;
    bound  = (s.live[FLD_BYP] || (s.cnt == 10'h000 && !s.out)) && !vco_i;
    use_cfg = s.live;
    if (load_i) begin
      next_s.pend = cfg_i;
      next_s.busy = 1'b1;
    end
    if (bound && s.busy) begin
      use_cfg     = s.pend;
      next_s.live = s.pend;
      next_s.busy = load_i;
    end
    if (restart_i) begin
      next_s.out = 1'b0;
      next_s.cnt = 10'h000;
    end else if (use_cfg[FLD_BYP]) begin
      next_s.out = !vco_i;
      next_s.cnt = 10'h000;
    end else if (bound) begin
      next_s.out = 1'b1;
      next_s.cnt = half_cyc(use_cfg[FLD_HIGH +: CNT_BITS]) - {9'h000, use_cfg[FLD_ODD]} - 10'h001;
    end else if (s.cnt != 10'h000) begin
      next_s.cnt = s.cnt - 10'h001;
    end else if (s.out) begin
      next_s.out = 1'b0;
      next_s.cnt = half_cyc(use_cfg[FLD_LOW +: CNT_BITS]) + {9'h000, use_cfg[FLD_ODD]} - 10'h001;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s      <= '0;
      s.live <= CNT_CFG_RST;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

  assign busy_o = s.busy;
  assign div_o  = s.out;
endmodule

// ---- src/psr_synth_dev.sv ----
// Purpose: synthesizer end: scan chain, update of live settings, post-scale dividers
// Assumes: link inputs are asynchronous; shift clock sampled by the system clock
// Notes:   oscillator modelled as the system clock divided by two
module psr_synth_dev
  import psr_pkg::*;
#(
  parameter int NUM_C = NUM_C_WIDE
)(
  input  wire logic             CLK_SYS_I,
  input  wire logic             RST_I,
  input  wire logic             CE_I,
  psr_link_if.dev               LINK,
  output logic [NUM_C-1:0]      CLK_OUT_O,
  output logic [FLD_LEN-1:0]    MULT_O,
  output logic [FLD_LEN-1:0]    PREDIV_O,
  output logic [2:0]            PUMP_O,
  output logic                  VCO_DIV_O,
  output logic [1:0]            LF_C_O,
  output logic [4:0]            LF_R_O,
  output logic                  SYNTH_RST_O
);
  localparam int LEN  = chain_len(NUM_C);  // chain length
  localparam int TAIL = NUM_C * FLD_LEN;   // tail base

  if (NUM_C != NUM_C_WIDE && NUM_C != NUM_C_NARROW) begin : g_bad
    $error("NUM_C must be 7 or 10");
  end

  typedef struct packed {
    logic [4:0]     sy1;       // first sync stage
    logic [4:0]     sy2;       // second sync stage
    logic           clk_prev;  // shift clock last cycle
    logic           en_seen;   // enable at last rise
    logic           upd_prev;  // apply at last rise
    logic [LEN-1:0] chain;     // scan chain
    logic           sdo;       // serial out
    logic [LEN-1:0] shadow;    // applied settings
    logic           apply;     // load pulse to counters
    logic           arming;    // load pulse delayed one cycle
    logic           busy;      // reconfiguration running
    logic           vco;       // oscillator level
    logic           synth_rst; // synthesizer reset
  } psr_dev_type;

  psr_dev_type      s, next_s;
  logic [NUM_C-1:0] cnt_busy;  // counters still pending
  logic             rise;      // shift clock rising edge

  // default settings: every counter bypassed
  function automatic logic [LEN-1:0] def_chain();
    logic [LEN-1:0] c;
    c = '0;
    for (int j = 0; j < NUM_C; j++) begin
      c[j * FLD_LEN + FLD_BYP] = 1'b1;
    end
    return c;
  endfunction

  // next state
  always_comb begin
    next_s     = s;
    next_s.sy1 = {LINK.synth_rst, LINK.cfg_apply, LINK.scan_din, LINK.scan_en, LINK.scan_clk};
    next_s.sy2 = s.sy1;
    next_s.clk_prev = s.sy2[SY_CLK];
    rise = s.sy2[SY_CLK] && !s.clk_prev;
    next_s.vco       = !s.vco;
    next_s.synth_rst = s.sy2[SY_RST];
    next_s.apply     = 1'b0;
    next_s.arming    = s.apply;
    if (rise) begin
      next_s.en_seen  = s.sy2[SY_EN];
      next_s.upd_prev = s.sy2[SY_UPD];
      if (s.en_seen && s.sy2[SY_EN]) begin
        next_s.chain = {s.sy2[SY_DIN], s.chain[LEN-1:1]};
      end
      if (s.sy2[SY_UPD] && !s.upd_prev && !s.busy) begin
        next_s.shadow = s.chain;
        next_s.apply  = 1'b1;
        next_s.busy   = 1'b1;
      end
    end
    next_s.sdo = next_s.chain[0];
    if (s.busy && !s.apply && !s.arming && cnt_busy == '0) begin
      next_s.busy = 1'b0;
    end
  end

  // state register
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      s        <= '0;
      s.shadow <= def_chain();
    end else if (CE_I) begin
      s <= next_s;
    end
  end

  // post-scale dividers, counter j at the chain end for lowest index last
  for (genvar j = 0; j < NUM_C; j++) begin : g_div
    psr_post_div u_div (
      .clk_i     (CLK_SYS_I),
      .rst_i     (RST_I),
      .ce_i      (CE_I),
      .vco_i     (s.vco),
      .restart_i (s.synth_rst),
      .load_i    (s.apply),
      .cfg_i     (s.shadow[(NUM_C - 1 - j) * FLD_LEN +: FLD_LEN]),
      .busy_o    (cnt_busy[j]),
      .div_o     (CLK_OUT_O[j])
    );
  end

  // link outputs
  assign LINK.reconf_busy = s.busy;
  assign LINK.scan_dout   = s.sdo;

  // applied tail settings
  assign MULT_O      = s.shadow[TAIL + TAIL_M +: FLD_LEN];
  assign PREDIV_O    = s.shadow[TAIL + TAIL_N +: FLD_LEN];
  assign PUMP_O      = s.shadow[TAIL + TAIL_CP +: 3];
  assign VCO_DIV_O   = s.shadow[TAIL + TAIL_K];
  assign LF_C_O      = s.shadow[TAIL + TAIL_LFC +: 2];
  assign LF_R_O      = s.shadow[TAIL + TAIL_LFR +: 5];
  assign SYNTH_RST_O = s.synth_rst;
endmodule

// ---- src/psr_synth_ctl.sv ----
// Purpose: controller end: holds a chain image, shifts it, applies it, resets the synthesizer
// Assumes: software uses the plain register port; device busy line is asynchronous
// Notes:   shift clock is divided from the system clock and runs freely
//
// Our own choices: the address-and-strobe port and the address map.
module psr_synth_ctl
  import psr_pkg::*;
#(
  parameter int NUM_C = NUM_C_WIDE
)(
  input  wire logic        CLK_SYS_I,
  input  wire logic        RST_I,
  input  wire logic        CE_I,
  psr_link_if.ctl          LINK,
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [31:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic [31:0]      RDATA_O
);
  localparam int LEN = chain_len(NUM_C);

  if ((NUM_C != NUM_C_WIDE && NUM_C != NUM_C_NARROW) || SCAN_HALF_CYC > 15) begin : g_bad
    $error("unsupported NUM_C or shift clock divider");
  end

  typedef struct packed {
    logic [IMG_WORDS-1:0][31:0] img;  // chain image
    logic          autorst;   // reset after update
    logic          go;        // start requested
    logic          phase;     // phase restore flag
    logic [31:0]   rdata;     // read data
    logic          sy1;       // busy sync stage 1
    logic          sy2;       // busy sync stage 2
    logic [3:0]    div;       // shift clock divider
    logic          sclk;      // shift clock
    psr_state_type st;        // sequence state
    logic [7:0]    bitcnt;    // bit being presented
    logic          en;        // shift enable
    logic          din;       // serial data
    logic          upd;       // apply request
    logic          arst;      // synthesizer reset
    logic [3:0]    acnt;      // reset length count
  } psr_ctl_type;

  psr_ctl_type s, next_s;
  logic        fall;  // shift clock falls at this edge

  // image bit i, bit 0 shifted first
  function automatic logic img_bit(input logic [IMG_WORDS-1:0][31:0] im, input logic [7:0] i);
    return im[i[7:5]][i[4:0]];
  endfunction

  // next state
  always_comb begin
    next_s       = s;
    next_s.sy1   = LINK.reconf_busy;
    next_s.sy2   = s.sy1;
    next_s.rdata = '0;
    fall = 1'b0;
    if (s.div == 4'(SCAN_HALF_CYC - 1)) begin
      next_s.div  = 4'h0;
      next_s.sclk = !s.sclk;
      fall        = s.sclk;
    end else begin
      next_s.div = s.div + 4'h1;
    end
    // register writes
    if (WR_I) begin
      if (ADDR_I == REG_CTRL) begin
        next_s.autorst = WDATA_I[CTRL_AUTORST];
        if (WDATA_I[CTRL_GO] && s.st == ST_IDLE) next_s.go = 1'b1;
      end else if (ADDR_I == REG_STATUS) begin
        if (WDATA_I[STAT_PHASE]) next_s.phase = 1'b0;
      end else if (ADDR_I >= REG_IMAGE && ADDR_I < REG_IMAGE + 8'(4 * IMG_WORDS)) begin
        next_s.img[3'((ADDR_I - REG_IMAGE) >> 2)] = WDATA_I;
      end
    end
    // register reads, data next cycle
    if (RD_I) begin
      if (ADDR_I == REG_CTRL) begin
        next_s.rdata[CTRL_AUTORST] = s.autorst;
      end else if (ADDR_I == REG_STATUS) begin
        next_s.rdata[STAT_BUSY]   = (s.st != ST_IDLE) || s.go;
        next_s.rdata[STAT_PHASE]  = s.phase;
        next_s.rdata[STAT_RECONF] = s.sy2;
      end else if (ADDR_I >= REG_IMAGE && ADDR_I < REG_IMAGE + 8'(4 * IMG_WORDS)) begin
        next_s.rdata = s.img[3'((ADDR_I - REG_IMAGE) >> 2)];
      end
    end
    unique case (s.st)
      ST_IDLE: begin
        if (fall && s.go) begin
          next_s.go = 1'b0;
          next_s.en = 1'b1;
          next_s.st = ST_ENA;
        end
      end
      ST_ENA: begin
        if (fall) begin
          next_s.din    = img_bit(s.img, 8'h00);
          next_s.bitcnt = 8'h00;
          next_s.st     = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (fall) begin
          if (s.bitcnt == 8'(LEN - 1)) begin
            next_s.en  = 1'b0;
            next_s.din = 1'b0;
            next_s.st  = ST_STOP;
          end else begin
            next_s.bitcnt = s.bitcnt + 8'h01;
            next_s.din    = img_bit(s.img, s.bitcnt + 8'h01);
          end
        end
      end
      ST_STOP: begin
        if (fall) begin
          next_s.upd = 1'b1;
          next_s.st  = ST_UPD;
        end
      end
      ST_UPD: begin
        if (fall) begin
          next_s.upd = 1'b0;
          next_s.st  = ST_WHI;
        end
      end
      ST_WHI: begin
        if (s.sy2) next_s.st = ST_WLO;
      end
      ST_WLO: begin
        if (!s.sy2) begin
          next_s.phase = 1'b1;
          next_s.acnt  = 4'h0;
          next_s.arst  = s.autorst;
          next_s.st    = s.autorst ? ST_ARST : ST_IDLE;
        end
      end
      ST_ARST: begin
        if (s.acnt == 4'(ARST_CYC - 1)) begin
          next_s.arst = 1'b0;
          next_s.st   = ST_IDLE;
        end else begin
          next_s.acnt = s.acnt + 4'h1;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge CLK_SYS_I) begin
    if (RST_I) begin
      s         <= '0;
      s.autorst <= CTRL_AUTORST_RST;
    end else if (CE_I) begin
      s <= next_s;
    end
  end

  assign LINK.scan_clk  = s.sclk;
  assign LINK.scan_en   = s.en;
  assign LINK.scan_din  = s.din;
  assign LINK.cfg_apply = s.upd;
  assign LINK.synth_rst = s.arst;
  assign RDATA_O        = s.rdata;
endmodule

// ---- testbench/psr_link_chk.sv ----
// Purpose: link protocol checks between controller end and synthesizer end
// Assumes: clock enables held high; divider counts kept small by the bench
// Notes:   sees only link signals plus system clock and reset
module psr_link_chk
  import psr_pkg::*;
(
  input  wire logic clk_sys_i,    // system clock
  input  wire logic rst_i,        // sync reset, active high
  input  wire logic scan_clk,     // shift clock
  input  wire logic scan_en,      // shift enable
  input  wire logic scan_din,     // serial data in
  input  wire logic cfg_apply,    // apply request
  input  wire logic synth_rst,    // synthesizer reset
  input  wire logic reconf_busy,  // update in progress
  input  wire logic scan_dout     // chain bit 0
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  property p_scan_clk_half;
    $rose(scan_clk) |-> scan_clk ##1 scan_clk ##1 !scan_clk ##1 !scan_clk ##1 scan_clk;
  endproperty
  a_scan_clk_half: assert property (p_scan_clk_half) else $error("shift clock period wrong");
  property p_free_run;
    !scan_clk |-> ##[1:4] scan_clk;
  endproperty
  a_free_run: assert property (p_free_run) else $error("shift clock stopped");
  property p_en_before_data;
    $rose(scan_en) |=> $stable(scan_din) [*3];
  endproperty
  a_en_before_data: assert property (p_en_before_data) else $error("data moved too soon after enable");
  property p_apply_idle;
    cfg_apply |-> !scan_en;
  endproperty
  a_apply_idle: assert property (p_apply_idle) else $error("apply while shifting");
  property p_apply_len;
    $rose(cfg_apply) |-> cfg_apply [*4] ##1 !cfg_apply;
  endproperty
  a_apply_len: assert property (p_apply_len) else $error("apply pulse length wrong");
  property p_busy_rise;
    $rose(cfg_apply) |-> ##[1:12] $rose(reconf_busy);
  endproperty
  a_busy_rise: assert property (p_busy_rise) else $error("busy did not rise after apply");
  property p_busy_fall;
    $rose(reconf_busy) |-> reconf_busy [*3] ##[0:400] !reconf_busy;
  endproperty
  a_busy_fall: assert property (p_busy_fall) else $error("busy did not fall");
  property p_rst_pulse;
    $rose(synth_rst) |-> !reconf_busy ##0 synth_rst [*3] ##1 !synth_rst;
  endproperty
  a_rst_pulse: assert property (p_rst_pulse) else $error("synth reset pulse wrong");
  property p_hold;
    !scan_en [*6] |-> $stable(scan_dout);
  endproperty
  a_hold: assert property (p_hold) else $error("chain moved with enable low");
  c_shift_end: cover property ($fell(scan_en));
  c_busy_end: cover property ($fell(reconf_busy));
  c_rst: cover property ($rose(synth_rst));
endmodule

// ---- testbench/tb_pll_scan_chain_reconfig.sv ----
// Purpose: bench for controller and synthesizer ends joined by the link
// Assumes: narrow variant; clock enables held high; small divider counts
// Notes:   register reads are checked against a queue of expected values
module tb_pll_scan_chain_reconfig
  import psr_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NC  = NUM_C_NARROW;        // counters in chain
  localparam int TB  = NC * FLD_LEN;        // tail base
  logic               clk_sys = 1'b0;       // system clock
  logic               rst     = 1'b1;       // sync reset
  logic               ce      = 1'b1;       // clock enable
  logic [7:0]         addr    = 8'h00;      // register address
  logic [31:0]        wdata   = 32'h0;      // write data
  logic               wr      = 1'b0;       // write strobe
  logic               rd      = 1'b0;       // read strobe
  logic [31:0]        rdata;                // read data
  logic [NC-1:0]      clk_out;              // divided outputs
  logic [FLD_LEN-1:0] mult;                 // applied feedback
  logic [FLD_LEN-1:0] prediv;               // applied pre-scale
  logic [2:0]         pump;                 // applied pump
  logic               vco_div;              // applied post divider
  logic [1:0]         lf_c;                 // applied capacitor
  logic [4:0]         lf_r;                 // applied resistor
  logic               synth_rst;            // synced synth reset
  int                 miscompares = 0;      // mismatch count
  int                 n_compared  = 0;      // comparison count
  int                 seed        = 32'h6474;
  int                 n_rst       = 0;      // synth reset pulses
  int                 n_busy      = 0;      // busy pulses
  int                 n_srst      = 0;      // device reset output pulses
  logic               srst_p      = 1'b0;   // device reset output last cycle
  logic [63:0]        exp_q[$];             // expected and mask per read
  logic               rd_d  = 1'b0;         // read one cycle ago
  logic               rst_p = 1'b0;         // reset line last cycle
  logic               bsy_p = 1'b0;         // busy line last cycle
  logic [31:0]        last_rd;              // last read value
  logic [255:0]       img;                  // chain image
  logic [255:0]       prev = '0;            // image applied before

  psr_link_if link();
  psr_synth_ctl #(.NUM_C(NC)) i_psr_synth_ctl (.CLK_SYS_I(clk_sys), .RST_I(rst), .CE_I(ce), .LINK(link),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata));
  psr_synth_dev #(.NUM_C(NC)) i_psr_synth_dev (.CLK_SYS_I(clk_sys), .RST_I(rst), .CE_I(ce), .LINK(link),
    .CLK_OUT_O(clk_out), .MULT_O(mult), .PREDIV_O(prediv), .PUMP_O(pump), .VCO_DIV_O(vco_div),
    .LF_C_O(lf_c), .LF_R_O(lf_r), .SYNTH_RST_O(synth_rst));
  psr_link_chk i_psr_link_chk (.clk_sys_i(clk_sys), .rst_i(rst), .scan_clk(link.scan_clk),
    .scan_en(link.scan_en), .scan_din(link.scan_din), .cfg_apply(link.cfg_apply),
    .synth_rst(link.synth_rst), .reconf_busy(link.reconf_busy), .scan_dout(link.scan_dout));

  // clock, 4 ns period
  always #2 clk_sys = ~clk_sys;

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic timeout(input string what);
    $display("CHECK FAILED %s expected done seen timeout", what);
    miscompares++;
    final_report();
  endtask

  // watcher: pulse counts and read compares
  always @(posedge clk_sys) begin
    rd_d  <= rd;
    rst_p <= link.synth_rst;
    bsy_p <= link.reconf_busy;
    srst_p <= synth_rst;
    if (synth_rst === 1'b1 && srst_p === 1'b0) n_srst++;
    if (link.synth_rst === 1'b1 && rst_p === 1'b0) n_rst++;
    if (link.reconf_busy === 1'b1 && bsy_p === 1'b0) n_busy++;
    if (rd_d === 1'b1) begin
      last_rd = rdata;
      if (exp_q[0][31:0] !== 32'h0) check("rdata", exp_q[0][63:32], rdata & exp_q[0][31:0]);
      void'(exp_q.pop_front());
    end
  end

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask

  // a zero mask only records the value
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back({e, m});
    @(posedge clk_sys);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
  endtask

  // divider high and low times in system cycles
  task automatic chk_div(input int k, input logic [FLD_LEN-1:0] f);
    int hi;
    int lo;
    int n;
    hi = 0;
    lo = 0;
    n  = 0;
    @(negedge clk_sys);
    while (clk_out[k] !== 1'b0 && n < 4000) begin @(negedge clk_sys); n++; end
    while (clk_out[k] !== 1'b1 && n < 4000) begin @(negedge clk_sys); n++; end
    while (clk_out[k] === 1'b1 && n < 4000) begin @(negedge clk_sys); hi++; n++; end
    while (clk_out[k] === 1'b0 && n < 4000) begin @(negedge clk_sys); lo++; n++; end
    if (n >= 4000) timeout("divider");
    check("div high", f[FLD_BYP] ? 32'h1 : 32'(2 * f[FLD_HIGH +: CNT_BITS] - f[FLD_ODD]), 32'(hi));
    check("div low", f[FLD_BYP] ? 32'h1 : 32'(2 * f[FLD_LOW +: CNT_BITS] + f[FLD_ODD]), 32'(lo));
  endtask

  // random image, counter 0 bypass chosen by caller
  task automatic make_img(input logic byp0);
    prev = img;
    img  = '0;
    for (int j = 0; j < NC; j++) begin
      img[j * FLD_LEN +: FLD_LEN] = {1'($random(seed)), (j == NC - 1) ? byp0 : 1'b0,
        4'h0, 4'($random(seed)) | 4'h1, 4'h0, 4'($random(seed)) | 4'h1};
    end
    for (int b = TB; b < TB + TAIL_LEN; b++) img[b] = 1'($random(seed));
    for (int k = 0; k < IMG_WORDS; k++) wr_reg(REG_IMAGE + 8'(4 * k), img[32 * k +: 32]);
  endtask

  // whole sequence: go, refused go, wait idle, check results
  task automatic run(input logic [31:0] ctrl, input int rst_exp, input logic hold);
    int r0;
    int b0;
    int n;
    int s0;
    r0 = n_rst;
    b0 = n_busy;
    s0 = n_srst;
    n  = 0;
    wr_reg(REG_CTRL, ctrl);
    while (link.scan_en !== 1'b1 && n < 100) begin @(posedge clk_sys); n++; end
    if (n >= 100) timeout("shift start");
    if (hold) check("mult held", 32'(prev[TB + TAIL_M +: FLD_LEN]), 32'(mult));
    wr_reg(REG_CTRL, ctrl);
    n = 0;
    do begin
      rd_reg(REG_STATUS, 32'h0, 32'h0);
      repeat (2) @(posedge clk_sys);
      n++;
    end while (last_rd[STAT_BUSY] !== 1'b0 && n < 2000);
    if (n >= 2000) timeout("status busy");
    check("busy pulses", 32'h1, 32'(n_busy - b0));
    check("reset pulses", 32'(rst_exp), 32'(n_rst - r0));
    check("synth reset out", 32'(rst_exp), 32'(n_srst - s0));
    check("mult", 32'(img[TB + TAIL_M +: FLD_LEN]), 32'(mult));
    check("prediv", 32'(img[TB + TAIL_N +: FLD_LEN]), 32'(prediv));
    check("tail", 32'({img[TB + TAIL_LFR +: 5], img[TB + TAIL_LFC +: 2], img[TB + TAIL_K], img[TB + TAIL_CP +: 3]}),
      32'({lf_r, lf_c, vco_div, pump}));
    check("scan_dout", 32'(img[0]), 32'(link.scan_dout));
    for (int k = 0; k < NC; k++) chk_div(k, img[(NC - 1 - k) * FLD_LEN +: FLD_LEN]);
    rd_reg(REG_STATUS, 32'h2, 32'h6);
    wr_reg(REG_STATUS, 32'h2);
    rd_reg(REG_STATUS, 32'h0, 32'h2);
  endtask

  // watchdog
  initial begin
    #400000;
    timeout("run");
  end

  // main sequence
  initial begin
    img = '0;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    rd_reg(REG_CTRL, 32'h2, 32'h2);
    rd_reg(REG_STATUS, 32'h0, 32'h7);
    wr_reg(8'h40, $random(seed));
    rd_reg(8'h40, 32'h0, 32'hffffffff);
    for (int k = 0; k < NC; k++) chk_div(k, CNT_CFG_RST);
    $display("test reset done");
    make_img(1'b1);
    run(32'h3, 1, 1'b0);
    $display("test first update done");
    make_img(1'b0);
    run(32'h1, 0, 1'b1);
    rd_reg(REG_CTRL, 32'h0, 32'h2);
    $display("test second update done");
    repeat (4) @(posedge clk_sys);
    final_report();
  end
endmodule
